// ---- rtl/vcc_consts.vh ----
// Purpose: shared constants of the capability check block
// Assumes: included by bare name from the rtl files
// Notes:   indices are register indices, not byte addresses
`ifndef VCC_CONSTS_VH
`define VCC_CONSTS_VH

// ==================================================
// register indices
`define VCC_IDX_BASIC      32'h00000480
`define VCC_IDX_PIN_LEG    32'h00000481
`define VCC_IDX_PROC_LEG   32'h00000482
`define VCC_IDX_SEC        32'h0000048B
`define VCC_IDX_PIN_FULL   32'h0000048D
`define VCC_IDX_PROC_FULL  32'h0000048E

// ==================================================
// field positions
`define VCC_BIT_TRUE_CTLS  55
`define VCC_BIT_SEC_ACT    31

// ==================================================
// reserved-one class members per control word
`define VCC_PIN_RSV1       32'h00000016
`define VCC_PROC_RSV1      32'h0401E172

// ==================================================
// reset values
`define VCC_RST_WORD       64'h0000000000000000
`define VCC_RST_CTL        32'h00000000

`endif

// ---- rtl/vcc_cap_regs.v ----
// Purpose: read-only capability register bank
// Assumes: allowed settings are fixed per build through parameters
// Notes:   values load at reset and are never written afterwards
`include "vcc_consts.vh"

module vcc_cap_regs #(
  parameter [31:0] PIN_ALLOW0  = 32'h00000000,
  parameter [31:0] PIN_ALLOW1  = 32'h0000007F,
  parameter [31:0] PROC_ALLOW0 = 32'h00000000,
  parameter [31:0] PROC_ALLOW1 = 32'hFFFFFFFE,
  parameter [31:0] SEC_ALLOW1  = 32'h000000FF,
  parameter [31:0] SEC_RSV0    = 32'hFFFFFF00,
  parameter        TRUE_CTLS   = 1'b1
) (
  input  wire        mclk_i,
  input  wire        srst_i,
  output reg  [63:0] basic_o,
  output reg  [63:0] pin_leg_o,
  output reg  [63:0] proc_leg_o,
  output reg  [63:0] sec_o,
  output reg  [63:0] pin_full_o,
  output reg  [63:0] proc_full_o,
  output reg         true_ctls_o,
  output reg         sec_present_o
);

  // ==================================================
  // register values
  // legacy pin forced
  wire [63:0] pin_leg_val   = {PIN_ALLOW1, PIN_ALLOW0 | `VCC_PIN_RSV1};
  wire [63:0] proc_leg_val  = {PROC_ALLOW1, PROC_ALLOW0 | `VCC_PROC_RSV1};
  wire [63:0] sec_val       = {SEC_ALLOW1 & ~SEC_RSV0, 32'h00000000};
  wire [63:0] pin_full_val  = {PIN_ALLOW1, PIN_ALLOW0};
  wire [63:0] proc_full_val = {PROC_ALLOW1, PROC_ALLOW0};
  wire        true_val      = TRUE_CTLS;
  reg  [63:0] basic_val;

  always @*
  begin
    basic_val = `VCC_RST_WORD;
    basic_val[`VCC_BIT_TRUE_CTLS] = true_val;
  end

  // ==================================================
  // storage
  // no write path
  always @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      basic_o       <= basic_val;
      pin_leg_o     <= pin_leg_val;
      proc_leg_o    <= proc_leg_val;
      sec_o         <= sec_val;
      pin_full_o    <= pin_full_val;
      proc_full_o   <= proc_full_val;
      true_ctls_o   <= true_val;
      sec_present_o <= PROC_ALLOW1[`VCC_BIT_SEC_ACT];
    end
  end

endmodule

// ---- rtl/vcc_entry_check.v ----
// Purpose: per-bit check of control words against capability words
// Assumes: capability words already selected legacy or full
// Notes:   purely combinational; caller registers the result
`include "vcc_consts.vh"

module vcc_entry_check #(
  parameter WIDTH = 32
) (
  input  wire [WIDTH-1:0] pin_ctl_i,
  input  wire [WIDTH-1:0] proc_ctl_i,
  input  wire [WIDTH-1:0] sec_ctl_i,
  input  wire [63:0]      pin_cap_i,
  input  wire [63:0]      proc_cap_i,
  input  wire [63:0]      sec_cap_i,
  output wire             pin_fail_o,
  output wire             proc_fail_o,
  output wire             sec_fail_o
);

  wire [WIDTH-1:0] pin_bad;
  wire [WIDTH-1:0] proc_bad;
  wire [WIDTH-1:0] sec_bad;
  wire             sec_on = proc_ctl_i[`VCC_BIT_SEC_ACT];

  genvar x;
  generate
    for (x = 0; x < WIDTH; x = x + 1)
    begin : g_bit
      assign pin_bad[x]  = (pin_cap_i[x] & ~pin_ctl_i[x]) |
                           (~pin_cap_i[32+x] & pin_ctl_i[x]);
      assign proc_bad[x] = (proc_cap_i[x] & ~proc_ctl_i[x]) |
                           (~proc_cap_i[32+x] & proc_ctl_i[x]);
      assign sec_bad[x]  = sec_on & sec_ctl_i[x] & ~sec_cap_i[32+x];
    end
  endgenerate

  assign pin_fail_o  = |pin_bad;
  assign proc_fail_o = |proc_bad;
  assign sec_fail_o  = |sec_bad;

endmodule

// ---- rtl/vcc_top.v ----
// Purpose: capability registers and control-word entry check
// Assumes: register port and entry request synchronous to mclk_i
// Notes:   one request per port at a time; see timing in code
`include "vcc_consts.vh"

module vcc_top #(
  parameter [31:0] PIN_ALLOW0  = 32'h00000000,
  parameter [31:0] PIN_ALLOW1  = 32'h0000007F,
  parameter [31:0] PROC_ALLOW0 = 32'h00000000,
  parameter [31:0] PROC_ALLOW1 = 32'hFFFFFFFE,
  parameter [31:0] SEC_ALLOW1  = 32'h000000FF,
  parameter [31:0] SEC_RSV0    = 32'hFFFFFF00,
  parameter        TRUE_CTLS   = 1'b1
) (
  input  wire        mclk_i,
  input  wire        srst_i,
  input  wire        reg_req_i,
  input  wire        reg_we_i,
  input  wire [31:0] reg_index_i,
  input  wire [63:0] reg_wdata_i,
  output reg         reg_ack_o,
  output reg  [63:0] reg_rdata_o,
  output reg         reg_gp_o,
  input  wire        entry_req_i,
  input  wire [31:0] pin_ctl_i,
  input  wire [31:0] proc_ctl_i,
  input  wire [31:0] sec_ctl_i,
  output reg         entry_busy_o,
  output reg         entry_done_o,
  output reg         entry_fail_o,
  output reg         fail_pin_o,
  output reg         fail_proc_o,
  output reg         fail_sec_o,
  output reg         true_ctls_o
);

  // ==================================================
  // state encodings
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_EVAL = 3'h2;
  localparam [2:0] ST_DONE = 3'h4;

  // ==================================================
  // capability bank
  wire [63:0] basic_w;
  wire [63:0] pin_leg_w;
  wire [63:0] proc_leg_w;
  wire [63:0] sec_w;
  wire [63:0] pin_full_w;
  wire [63:0] proc_full_w;
  wire        true_w;
  wire        sec_present_w;

  vcc_cap_regs #(
    .PIN_ALLOW0  (PIN_ALLOW0),
    .PIN_ALLOW1  (PIN_ALLOW1),
    .PROC_ALLOW0 (PROC_ALLOW0),
    .PROC_ALLOW1 (PROC_ALLOW1),
    .SEC_ALLOW1  (SEC_ALLOW1),
    .SEC_RSV0    (SEC_RSV0),
    .TRUE_CTLS   (TRUE_CTLS)
  ) u_caps (
    .mclk_i        (mclk_i),
    .srst_i        (srst_i),
    .basic_o       (basic_w),
    .pin_leg_o     (pin_leg_w),
    .proc_leg_o    (proc_leg_w),
    .sec_o         (sec_w),
    .pin_full_o    (pin_full_w),
    .proc_full_o   (proc_full_w),
    .true_ctls_o   (true_w),
    .sec_present_o (sec_present_w)
  );

  // ==================================================
  // register read decode
  reg  [63:0] next_rdata;
  reg         next_gp;
  reg         next_hit;

  always @*
  begin
    next_rdata = `VCC_RST_WORD;
    next_hit   = 1'b1;
    case (reg_index_i)
      `VCC_IDX_BASIC:
        next_rdata = basic_w;
      `VCC_IDX_PIN_LEG:
        next_rdata = pin_leg_w;
      `VCC_IDX_PROC_LEG:
        next_rdata = proc_leg_w;
      `VCC_IDX_SEC:
      begin
        next_rdata = sec_present_w ? sec_w : `VCC_RST_WORD;
        next_hit   = sec_present_w;
      end
      `VCC_IDX_PIN_FULL:
      begin
        next_rdata = true_w ? pin_full_w : `VCC_RST_WORD;
        next_hit   = true_w;
      end
      `VCC_IDX_PROC_FULL:
      begin
        next_rdata = true_w ? proc_full_w : `VCC_RST_WORD;
        next_hit   = true_w;
      end
      default:
        next_hit = 1'b0;
    endcase
    next_gp = reg_we_i | ~next_hit;
    if (next_gp)
    begin
      next_rdata = `VCC_RST_WORD;
    end
  end

  // write data is never stored: the bank has no write path at all
  always @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      reg_ack_o   <= 1'b0;
      reg_rdata_o <= `VCC_RST_WORD;
      reg_gp_o    <= 1'b0;
    end
    else
    begin
      reg_ack_o <= reg_req_i;
      if (reg_req_i)
      begin
        reg_rdata_o <= next_rdata;
        reg_gp_o    <= next_gp;
      end
      else
      begin
        reg_gp_o <= 1'b0;
      end
    end
  end

  // ==================================================
  // capability selection for the entry check
  // legacy words carry forced class bits
  wire [63:0] pin_sel  = true_w ? pin_full_w  : pin_leg_w;
  wire [63:0] proc_sel = true_w ? proc_full_w : proc_leg_w;

  reg  [31:0] pin_cap_ctl;
  reg  [31:0] proc_cap_ctl;
  reg  [31:0] sec_cap_ctl;
  wire        pin_bad_w;
  wire        proc_bad_w;
  wire        sec_bad_w;

  vcc_entry_check #(
    .WIDTH (32)
  ) u_check (
    .pin_ctl_i   (pin_cap_ctl),
    .proc_ctl_i  (proc_cap_ctl),
    .sec_ctl_i   (sec_cap_ctl),
    .pin_cap_i   (pin_sel),
    .proc_cap_i  (proc_sel),
    .sec_cap_i   (sec_w),
    .pin_fail_o  (pin_bad_w),
    .proc_fail_o (proc_bad_w),
    .sec_fail_o  (sec_bad_w)
  );

  // ==================================================
  // entry sequencer
  reg [2:0] state;
  reg [2:0] next_state;

  always @*
  begin
    next_state = state;
    case (state)
      ST_IDLE:
        next_state = entry_req_i ? ST_EVAL : ST_IDLE;
      ST_EVAL:
        next_state = ST_DONE;
      ST_DONE:
        next_state = ST_IDLE;
      default:
        next_state = ST_IDLE;
    endcase
  end

  // requests arriving while busy are dropped, not queued
  always @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      state        <= ST_IDLE;
      pin_cap_ctl  <= `VCC_RST_CTL;
      proc_cap_ctl <= `VCC_RST_CTL;
      sec_cap_ctl  <= `VCC_RST_CTL;
      entry_busy_o <= 1'b0;
    end
    else
    begin
      state <= next_state;
      case (state)
        ST_IDLE:
        begin
          if (entry_req_i)
          begin
            pin_cap_ctl  <= pin_ctl_i;
            proc_cap_ctl <= proc_ctl_i;
            sec_cap_ctl  <= sec_ctl_i;
            entry_busy_o <= 1'b1;
          end
        end
        ST_EVAL:
        begin
          entry_busy_o <= 1'b0;
        end
        ST_DONE:
        begin
          entry_busy_o <= 1'b0;
        end
        default:
        begin
          entry_busy_o <= 1'b0;
        end
      endcase
    end
  end

  // ==================================================
  // entry result
  // combined failure
  wire any_bad = pin_bad_w | proc_bad_w | sec_bad_w;
  wire in_eval = (state == ST_EVAL);

  // results held until the next evaluation so software may read them late
  always @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      entry_done_o <= 1'b0;
      entry_fail_o <= 1'b0;
      fail_pin_o   <= 1'b0;
      fail_proc_o  <= 1'b0;
      fail_sec_o   <= 1'b0;
    end
    else
    begin
      entry_done_o <= in_eval;
      if (in_eval)
      begin
        entry_fail_o <= any_bad;
        fail_pin_o   <= pin_bad_w;
        fail_proc_o  <= proc_bad_w;
        fail_sec_o   <= sec_bad_w;
      end
    end
  end

  // ==================================================
  // flag copy
  // flag mirrored on a pin
  always @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      true_ctls_o <= 1'b0;
    end
    else
    begin
      true_ctls_o <= true_w;
    end
  end

endmodule

// ---- bench/vcc_top_sva.sv ----
// Purpose: concurrent checks on the capability block ports
// Assumes: one clock, synchronous active-high reset
// Notes:   bound to every vcc_top instance
`include "vcc_consts.vh"

module vcc_top_sva #(
  parameter        TRUE_CTLS = 1'b1,
  parameter [31:0] SEC_RSV0  = 32'hFFFFFF00
) (
  input wire        mclk_i,
  input wire        srst_i,
  input wire        reg_req_i,
  input wire        reg_we_i,
  input wire [31:0] reg_index_i,
  input wire        reg_ack_o,
  input wire [63:0] reg_rdata_o,
  input wire        reg_gp_o,
  input wire        entry_req_i,
  input wire        entry_busy_o,
  input wire        entry_done_o,
  input wire        entry_fail_o,
  input wire        fail_pin_o,
  input wire        fail_proc_o,
  input wire        fail_sec_o
);
  timeunit 1ns;
  timeprecision 1ps;

  wire rd = reg_req_i && !reg_we_i;

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (srst_i);

  // ==================================================
  // register port
  a_ack_follows: assert property (reg_req_i |=> reg_ack_o)
    else $error("no ack after request");
  a_ack_cause: assert property (reg_ack_o |-> $past(reg_req_i))
    else $error("ack without request");
  a_write_fault: assert property (reg_req_i && reg_we_i |=> reg_gp_o && reg_rdata_o == 64'h0)
    else $error("write did not fault");
  a_full_gate: assert property (rd && (reg_index_i == `VCC_IDX_PIN_FULL ||
    reg_index_i == `VCC_IDX_PROC_FULL) |=> reg_gp_o == !TRUE_CTLS)
    else $error("full register presence wrong");
  a_basic_flag: assert property (rd && reg_index_i == `VCC_IDX_BASIC |=>
    reg_rdata_o[55] == TRUE_CTLS && !reg_gp_o)
    else $error("flag bit wrong");
  a_pin_forced: assert property (rd && reg_index_i == `VCC_IDX_PIN_LEG |=>
    (reg_rdata_o[31:0] & `VCC_PIN_RSV1) == `VCC_PIN_RSV1)
    else $error("legacy pin bits not forced");
  a_proc_forced: assert property (rd && reg_index_i == `VCC_IDX_PROC_LEG |=>
    (reg_rdata_o[31:0] & `VCC_PROC_RSV1) == `VCC_PROC_RSV1)
    else $error("legacy primary bits not forced");
  a_sec_shape: assert property (rd && reg_index_i == `VCC_IDX_SEC |=>
    reg_rdata_o[31:0] == 32'h0 && (reg_rdata_o[63:32] & SEC_RSV0) == 32'h0)
    else $error("secondary word shape wrong");

  // ==================================================
  // entry check
  a_entry_seq: assert property (entry_req_i && !entry_busy_o && !entry_done_o |=>
    entry_busy_o ##1 (entry_done_o && !entry_busy_o))
    else $error("entry sequence timing wrong");
  a_fail_or: assert property (entry_done_o |->
    entry_fail_o == (fail_pin_o || fail_proc_o || fail_sec_o))
    else $error("combined fail wrong");
  a_fail_hold: assert property (1'b1 ##1 !entry_done_o |-> $stable(entry_fail_o))
    else $error("fail changed outside done");
endmodule

bind vcc_top vcc_top_sva #(
  .TRUE_CTLS (TRUE_CTLS),
  .SEC_RSV0  (SEC_RSV0)
) u_sva (
  .mclk_i       (mclk_i),
  .srst_i       (srst_i),
  .reg_req_i    (reg_req_i),
  .reg_we_i     (reg_we_i),
  .reg_index_i  (reg_index_i),
  .reg_ack_o    (reg_ack_o),
  .reg_rdata_o  (reg_rdata_o),
  .reg_gp_o     (reg_gp_o),
  .entry_req_i  (entry_req_i),
  .entry_busy_o (entry_busy_o),
  .entry_done_o (entry_done_o),
  .entry_fail_o (entry_fail_o),
  .fail_pin_o   (fail_pin_o),
  .fail_proc_o  (fail_proc_o),
  .fail_sec_o   (fail_sec_o)
);

// ---- bench/vcc_top_test.sv ----
// Purpose: self-checking bench of the capability block
// Assumes: two instances, one with the flag set and one with it clear
// Notes:   allowed settings set off default to exercise low halves
module vcc_top_test;
  timeunit 1ns;
  timeprecision 1ps;

  localparam [31:0] P0 = 32'h00000009;
  localparam [31:0] P1 = 32'h0000007F;
  localparam [31:0] R0 = 32'h00000400;
  localparam [31:0] R1 = 32'hFFFFFFFE;
  localparam [31:0] S1 = 32'h0000FFFF;
  localparam [31:0] SR = 32'hFFFFFF00;

  logic        clk, srst, rq, we, er, ack, gp, bsy, dn, fl, fp, fr, fs, tc;
  logic        ack2, gp2, bsy2, dn2, fl2, fp2, fr2, fs2, tc2;
  logic [63:0] rd2;
  logic [31:0] ix, pc, rc, sc;
  logic [63:0] wd, rd;
  int          num_errors = 0;
  int          tests_run  = 0;
  logic [31:0] ixs [6] = '{32'h480, 32'h481, 32'h482, 32'h48B, 32'h48D, 32'h48E};
  logic [63:0] exv [6] = '{64'h0080000000000000, {P1, P0 | 32'h16},
    {R1, R0 | 32'h0401E172}, {S1 & ~SR, 32'h0}, {P1, P0}, {R1, R0}};

  vcc_top #(
    .PIN_ALLOW0  (P0),
    .PIN_ALLOW1  (P1),
    .PROC_ALLOW0 (R0),
    .PROC_ALLOW1 (R1),
    .SEC_ALLOW1  (S1),
    .SEC_RSV0    (SR),
    .TRUE_CTLS   (1'b1)
  ) u_dut (
    .mclk_i       (clk),
    .srst_i       (srst),
    .reg_req_i    (rq),
    .reg_we_i     (we),
    .reg_index_i  (ix),
    .reg_wdata_i  (wd),
    .reg_ack_o    (ack),
    .reg_rdata_o  (rd),
    .reg_gp_o     (gp),
    .entry_req_i  (er),
    .pin_ctl_i    (pc),
    .proc_ctl_i   (rc),
    .sec_ctl_i    (sc),
    .entry_busy_o (bsy),
    .entry_done_o (dn),
    .entry_fail_o (fl),
    .fail_pin_o   (fp),
    .fail_proc_o  (fr),
    .fail_sec_o   (fs),
    .true_ctls_o  (tc)
  );

  // same inputs, legacy words selected
  vcc_top #(
    .PIN_ALLOW0  (P0),
    .PIN_ALLOW1  (P1),
    .PROC_ALLOW0 (R0),
    .PROC_ALLOW1 (R1),
    .SEC_ALLOW1  (S1),
    .SEC_RSV0    (SR),
    .TRUE_CTLS   (1'b0)
  ) u_dut_leg (
    .mclk_i       (clk),
    .srst_i       (srst),
    .reg_req_i    (rq),
    .reg_we_i     (we),
    .reg_index_i  (ix),
    .reg_wdata_i  (wd),
    .reg_ack_o    (ack2),
    .reg_rdata_o  (rd2),
    .reg_gp_o     (gp2),
    .entry_req_i  (er),
    .pin_ctl_i    (pc),
    .proc_ctl_i   (rc),
    .sec_ctl_i    (sc),
    .entry_busy_o (bsy2),
    .entry_done_o (dn2),
    .entry_fail_o (fl2),
    .fail_pin_o   (fp2),
    .fail_proc_o  (fr2),
    .fail_sec_o   (fs2),
    .true_ctls_o  (tc2)
  );

  // ==================================================
  // helpers
  task chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task tally_and_finish;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // one access, answer registered on the taking edge and checked just after it
  task acc(input logic w, input logic [31:0] i, input logic [63:0] e, input logic g);
    logic        nf;
    logic [63:0] e2;
    nf = !w && (i == 32'h48D || i == 32'h48E);
    e2 = (nf || i == 32'h480) ? 64'h0 : e;
    @(posedge clk) #1;
    {rq, we, ix, wd} = {1'b1, w, i, $urandom, $urandom};
    @(posedge clk) #1;
    rq = 0;
    chk(ack, 1);
    chk(gp, g);
    chk(rd, e);
    chk(ack2, 1);
    chk(gp2, g | nf);
    chk(rd2, e2);
  endtask

  // expected fails worked out bit by bit from the allowed settings
  task ent(input logic [31:0] a, input logic [31:0] b, input logic [31:0] c);
    logic fa, fb, fc, la, lb;
    fa = |(P0 & ~a) | |(~P1 & a);
    fb = |(R0 & ~b) | |(~R1 & b);
    la = |((P0 | 32'h16) & ~a) | |(~P1 & a);
    lb = |((R0 | 32'h0401E172) & ~b) | |(~R1 & b);
    fc = b[31] & |(c & ~(S1 & ~SR));
    @(posedge clk) #1;
    {er, pc, rc, sc} = {1'b1, a, b, c};
    @(posedge clk) #1;
    er = 0;
    chk(bsy, 1);
    chk(bsy2, 1);
    @(posedge clk) #1;
    chk({dn, fp, fr, fs}, {1'b1, fa, fb, fc});
    chk(fl, fa | fb | fc);
    chk({dn2, fp2, fr2, fs2}, {1'b1, la, lb, fc});
    chk(fl2, la | lb | fc);
  endtask

  // ==================================================
  // clock, watchdog, sequence
  initial
  begin
    clk = 0;
    forever #5 clk = ~clk;
  end

  initial
  begin
    #50000;
    num_errors++;
    tally_and_finish;
  end

  initial
  begin
    {srst, rq, we, er, ix, wd, pc, rc, sc} = '0;
    srst = 1;
    void'($urandom(64));
    repeat (5) @(posedge clk);
    #1;
    srst = 0;
    for (int k = 0; k < 6; k++) acc(0, ixs[k], exv[k], 0);
    for (int k = 0; k < 6; k++) acc(1, ixs[k], 64'h0, 1);
    for (int k = 0; k < 6; k++) acc(0, ixs[k], exv[k], 0);
    acc(0, 32'h483, 64'h0, 1);
    acc(1, 32'h4A0, 64'h0, 1);
    chk(tc, 1);
    chk(tc2, 0);
    ent(P0, R0, 32'h0);
    ent(P0 | 32'h16, R0 | 32'h0401E172, 32'h0);
    ent(32'h0, R0, 32'h0);
    ent(P0 | 32'h80, R0, 32'h0);
    ent(P0, R0 | 32'h1, 32'h0);
    ent(P0, R0 | 32'h80000000, 32'h100);
    ent(P0, R0, 32'h100);
    repeat (150)
      ent(($urandom & P1 | P0) ^ (32'h1 << $urandom % 9),
          ($urandom & R1 | R0) ^ (32'h1 << $urandom % 11), $urandom & 32'h1FF);
    tally_and_finish;
  end
endmodule
